// >>> common/rtb_map.svh
`ifndef RTB_MAP_SVH
`define RTB_MAP_SVH
// Register indices; byte address is index times four
`define RTB_IDX_PHASE_LO 8'h24
`define RTB_IDX_PHASE_HI 8'h25
`define RTB_IDX_DC_LO 8'h26
`define RTB_IDX_DC_HI 8'h27
`define RTB_IDX_FACTORY 8'h28
`define RTB_IDX_TXGAIN 8'h29
`define RTB_IDX_HIST_LO 8'h2a
`define RTB_IDX_HIST_HI 8'h2b
`define RTB_IDX_HOLD_LO 8'h2c
`define RTB_IDX_HOLD_HI 8'h2d
`define RTB_IDX_LOCK 8'h2e
`define RTB_IDX_UPPER_LO 8'h30
`define RTB_IDX_UPPER_HI 8'h31
`define RTB_IDX_LOWER_LO 8'h32
`define RTB_IDX_LOWER_HI 8'h33
`define RTB_IDX_QUAL_LO 8'h34
`define RTB_IDX_QUAL_HI 8'h35
`define RTB_IDX_UNIT_LO 8'h36
`define RTB_IDX_UNIT_HI 8'h37
`define RTB_IDX_SETPT_LO 8'h38
`define RTB_IDX_SETPT_HI 8'h39
`define RTB_IDX_CTRL 8'h40
`define RTB_IDX_IRQ_STAT 8'h41
`define RTB_IDX_IRQ_CLR 8'h42
`define RTB_IDX_IRQ_EN 8'h43
`define RTB_IDX_CNT_LO 8'h44
`define RTB_IDX_CNT_HI 8'h45
`define RTB_IDX_SYNC_STAT 8'h46
// Field positions
`define RTB_GAIN_MSB 5
`define RTB_GAIN_LSB 2
`define RTB_CTRL_AUTO_SYNC 0
`define RTB_CTRL_EQ_SEL 1
`define RTB_CTRL_TWO_LEVEL 2
`define RTB_IRQ_FE_HIGH 0
`define RTB_IRQ_FE_LOW 1
`define RTB_IRQ_LOW_SNR 2
`define RTB_IRQ_SYNC 3
// Reset values and timing counts
`define RTB_RST16 16'h0000
`define RTB_RST8 8'h00
`define RTB_PAUSE_SYMBOLS 3'h5
`define RTB_DESCR_CYCLES 8'h17
`define RTB_ONES_CYCLES 8'h80
`endif

// >>> common/rtb_pkg.sv
package rtb_pkg;
	typedef struct packed {
		logic symbol_valid;
		logic signed [15:0] phase_det;
		logic signed [15:0] rx_raw;
		logic signed [15:0] dfe_out;
		logic signed [15:0] dagc_out;
		logic signed [15:0] ep_correction;
		logic signed [15:0] far_end_meter;
		logic signed [15:0] snr_meter;
		logic meter_valid;
		logic scr_bit;
		logic det_bit;
	} rtb_dsp_in_s;
	typedef struct packed {
		logic signed [15:0] phase_corr;
		logic signed [15:0] rx_corr;
		logic signed [15:0] ep_corr_out;
		logic signed [2:0] symbol;
		logic signed [15:0] slicer_err;
		logic signed [15:0] dagc_err;
		logic [3:0] tx_gain;
		logic hist_hit;
		logic [1:0] scr_mode;
	} rtb_dsp_out_s;
	typedef enum logic [3:0] {
		RTB_SYNC_OFF = 4'h1,
		RTB_SYNC_DESCR = 4'h2,
		RTB_SYNC_ONES = 4'h4,
		RTB_SYNC_DONE = 4'h8
	} rtb_sync_e;
	typedef logic signed [15:0] rtb_word_t;
endpackage

// >>> core/rtb_core.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rtb_map.svh"
module rtb_core #(
	parameter logic [3:0] FACTORY_TRIM = 4'h0 // Arbitrary value
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire rtb_pkg::rtb_dsp_in_s dsp_in, // Datapath samples
	output rtb_pkg::rtb_dsp_out_s dsp_out, // Corrected datapath
	output logic irq // Level interrupt
);
	function automatic rtb_pkg::rtb_word_t mag16(input rtb_pkg::rtb_word_t v);
		mag16 = v[15] ? -v : v;
	endfunction

	logic [15:0] phase_error_offset;
	logic [15:0] receive_dc_trim;
	logic [7:0] transmit_level_adjust;
	logic [15:0] error_count_level;
	logic [15:0] predictor_hold_level;
	logic [7:0] descrambler_lock_level;
	logic [15:0] remote_level_upper_limit;
	logic [15:0] remote_level_lower_limit;
	logic [15:0] quality_alarm_limit;
	logic [15:0] unit_symbol_level;
	logic [15:0] gain_loop_setpoint;
	logic [7:0] ctrl;
	logic [3:0] irq_status;
	logic [3:0] irq_enable;
	logic [15:0] hist_count;
	logic [7:0] wr_low_stage;
	logic [7:0] rd_high_stage;
	logic [2:0] pause_left;
	logic [7:0] phase_cnt;
	logic [7:0] match_cnt;
	rtb_pkg::rtb_sync_e sync_state;
	rtb_pkg::rtb_sync_e next_sync_state;

	logic [7:0] idx;
	logic setup;
	logic wr_en;
	logic mapped;
	logic [15:0] wr_word;
	logic [7:0] rd_byte;
	logic [3:0] clr_mask;
	logic [3:0] irq_events;
	logic sync_event;
	logic auto_sync;
	logic eq_select;
	logic two_level;
	rtb_pkg::rtb_word_t slice_thr;
	rtb_pkg::rtb_word_t scaled;
	rtb_pkg::rtb_word_t err_now;
	rtb_pkg::rtb_word_t err_mag;
	logic signed [2:0] sym_now;
	logic hold_hit;
	logic hist_hit_now;
	logic match;

	assign idx = paddr[9:2];
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign wr_word = {pwdata[7:0], wr_low_stage};
	assign auto_sync = ctrl[`RTB_CTRL_AUTO_SYNC];
	assign eq_select = ctrl[`RTB_CTRL_EQ_SEL];
	assign two_level = ctrl[`RTB_CTRL_TWO_LEVEL];
	assign match = dsp_in.scr_bit == dsp_in.det_bit;

	// Read decode; high halves come from the snapshot taken at low read
	always_comb
	begin
		rd_byte = `RTB_RST8;
		mapped = 1'b1;
		case (idx)
			`RTB_IDX_PHASE_LO: rd_byte = phase_error_offset[7:0];
			`RTB_IDX_DC_LO: rd_byte = receive_dc_trim[7:0];
			`RTB_IDX_HIST_LO: rd_byte = error_count_level[7:0];
			`RTB_IDX_HOLD_LO: rd_byte = predictor_hold_level[7:0];
			`RTB_IDX_UPPER_LO: rd_byte = remote_level_upper_limit[7:0];
			`RTB_IDX_LOWER_LO: rd_byte = remote_level_lower_limit[7:0];
			`RTB_IDX_QUAL_LO: rd_byte = quality_alarm_limit[7:0];
			`RTB_IDX_UNIT_LO: rd_byte = unit_symbol_level[7:0];
			`RTB_IDX_SETPT_LO: rd_byte = gain_loop_setpoint[7:0];
			`RTB_IDX_CNT_LO: rd_byte = hist_count[7:0];
			`RTB_IDX_PHASE_HI, `RTB_IDX_DC_HI, `RTB_IDX_HIST_HI,
			`RTB_IDX_HOLD_HI, `RTB_IDX_UPPER_HI, `RTB_IDX_LOWER_HI,
			`RTB_IDX_QUAL_HI, `RTB_IDX_UNIT_HI, `RTB_IDX_SETPT_HI,
			`RTB_IDX_CNT_HI: rd_byte = rd_high_stage;
			`RTB_IDX_FACTORY: rd_byte = {2'h0, FACTORY_TRIM, 2'h0};
			`RTB_IDX_TXGAIN: rd_byte = transmit_level_adjust;
			`RTB_IDX_LOCK: rd_byte = descrambler_lock_level;
			`RTB_IDX_CTRL: rd_byte = ctrl;
			`RTB_IDX_IRQ_STAT: rd_byte = {4'h0, irq_status};
			`RTB_IDX_IRQ_CLR: rd_byte = `RTB_RST8;
			`RTB_IDX_IRQ_EN: rd_byte = {4'h0, irq_enable};
			`RTB_IDX_SYNC_STAT: rd_byte = {4'h0, sync_state};
			default: mapped = 1'b0;
		endcase
	end

	// APB answer: data and ready registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0;
		end
	end

	// Byte staging keeps each wide value whole
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_low_stage <= `RTB_RST8;
			rd_high_stage <= `RTB_RST8;
		end
		else
		begin
			if (wr_en)
				wr_low_stage <= pwdata[7:0];
			if (setup & ~pwrite)
			begin
				case (idx)
					`RTB_IDX_PHASE_LO: rd_high_stage <= phase_error_offset[15:8];
					`RTB_IDX_DC_LO: rd_high_stage <= receive_dc_trim[15:8];
					`RTB_IDX_HIST_LO: rd_high_stage <= error_count_level[15:8];
					`RTB_IDX_HOLD_LO: rd_high_stage <= predictor_hold_level[15:8];
					`RTB_IDX_UPPER_LO:
						rd_high_stage <= remote_level_upper_limit[15:8];
					`RTB_IDX_LOWER_LO:
						rd_high_stage <= remote_level_lower_limit[15:8];
					`RTB_IDX_QUAL_LO: rd_high_stage <= quality_alarm_limit[15:8];
					`RTB_IDX_UNIT_LO: rd_high_stage <= unit_symbol_level[15:8];
					`RTB_IDX_SETPT_LO: rd_high_stage <= gain_loop_setpoint[15:8];
					`RTB_IDX_CNT_LO: rd_high_stage <= hist_count[15:8];
					default: rd_high_stage <= rd_high_stage;
				endcase
			end
		end
	end

	// Register writes; wide values commit on the high byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_error_offset <= `RTB_RST16;
			receive_dc_trim <= `RTB_RST16;
			transmit_level_adjust <= `RTB_RST8;
			error_count_level <= `RTB_RST16;
			predictor_hold_level <= `RTB_RST16;
			descrambler_lock_level <= `RTB_RST8;
			remote_level_upper_limit <= `RTB_RST16;
			remote_level_lower_limit <= `RTB_RST16;
			quality_alarm_limit <= `RTB_RST16;
			unit_symbol_level <= `RTB_RST16;
			gain_loop_setpoint <= `RTB_RST16;
			ctrl <= `RTB_RST8;
			irq_enable <= 4'h0;
		end
		else if (wr_en)
		begin
			case (idx)
				`RTB_IDX_PHASE_HI: phase_error_offset <= wr_word;
				`RTB_IDX_DC_HI: receive_dc_trim <= wr_word;
				`RTB_IDX_TXGAIN: transmit_level_adjust <=
					{2'h0, pwdata[`RTB_GAIN_MSB:`RTB_GAIN_LSB], 2'h0};
				`RTB_IDX_HIST_HI: error_count_level <= wr_word;
				`RTB_IDX_HOLD_HI: predictor_hold_level <= wr_word;
				`RTB_IDX_LOCK: descrambler_lock_level <= {1'b0, pwdata[6:0]};
				`RTB_IDX_UPPER_HI: remote_level_upper_limit <= wr_word;
				`RTB_IDX_LOWER_HI: remote_level_lower_limit <= wr_word;
				`RTB_IDX_QUAL_HI: quality_alarm_limit <= wr_word;
				`RTB_IDX_UNIT_HI: unit_symbol_level <= wr_word;
				`RTB_IDX_SETPT_HI: gain_loop_setpoint <= wr_word;
				`RTB_IDX_CTRL: ctrl <= {5'h00, pwdata[2:0]};
				`RTB_IDX_IRQ_EN: irq_enable <= pwdata[3:0];
				default: ctrl <= ctrl;
			endcase
		end
	end

	// Slicer and symbol scaling
	always_comb
	begin
		slice_thr = rtb_pkg::rtb_word_t'(unit_symbol_level <<< 1);
		if (two_level)
			sym_now = dsp_in.dfe_out[15] ? -3'sd3 : 3'sd3;
		else if (dsp_in.dfe_out >= slice_thr)
			sym_now = 3'sd3;
		else if (dsp_in.dfe_out >= 16'sh0000)
			sym_now = 3'sd1;
		else if (dsp_in.dfe_out >= -slice_thr)
			sym_now = -3'sd1;
		else
			sym_now = -3'sd3;
		case (sym_now)
			3'sd3: scaled = rtb_pkg::rtb_word_t'(unit_symbol_level * 3);
			3'sd1: scaled = unit_symbol_level;
			-3'sd1: scaled = -unit_symbol_level;
			default: scaled = rtb_pkg::rtb_word_t'(-(unit_symbol_level * 3));
		endcase
		err_now = dsp_in.dfe_out - scaled;
		err_mag = mag16(err_now);
		hist_hit_now = err_mag > error_count_level;
		hold_hit = err_mag > predictor_hold_level;
	end

	// Hold timer for the predictor correction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pause_left <= 3'h0;
		else if (dsp_in.symbol_valid)
		begin
			if (hold_hit)
				pause_left <= `RTB_PAUSE_SYMBOLS - 3'h1;
			else if (pause_left != 3'h0)
				pause_left <= pause_left - 3'h1;
		end
	end

	// Histogram meter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hist_count <= `RTB_RST16;
		else if (dsp_in.symbol_valid && hist_hit_now && hist_count != 16'hffff)
			hist_count <= hist_count + 16'h0001;
	end

	// Automatic scrambler sync sequencer
	always_comb
	begin
		next_sync_state = sync_state;
		sync_event = 1'b0;
		case (sync_state)
			rtb_pkg::RTB_SYNC_OFF:
				if (auto_sync)
					next_sync_state = rtb_pkg::RTB_SYNC_DESCR;
			rtb_pkg::RTB_SYNC_DESCR:
				if (dsp_in.symbol_valid && phase_cnt == `RTB_DESCR_CYCLES - 8'h1)
					next_sync_state = rtb_pkg::RTB_SYNC_ONES;
			rtb_pkg::RTB_SYNC_ONES:
				if (match_cnt > descrambler_lock_level)
				begin
					next_sync_state = rtb_pkg::RTB_SYNC_DONE;
					sync_event = 1'b1;
				end
				else if (dsp_in.symbol_valid &&
					phase_cnt == `RTB_ONES_CYCLES - 8'h1)
					next_sync_state = rtb_pkg::RTB_SYNC_DESCR;
			rtb_pkg::RTB_SYNC_DONE:
				next_sync_state = rtb_pkg::RTB_SYNC_DONE;
			default:
				next_sync_state = rtb_pkg::RTB_SYNC_OFF;
		endcase
		if (!auto_sync)
			next_sync_state = rtb_pkg::RTB_SYNC_OFF;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_state <= rtb_pkg::RTB_SYNC_OFF;
			phase_cnt <= 8'h00;
			match_cnt <= 8'h00;
		end
		else
		begin
			sync_state <= next_sync_state;
			if (next_sync_state != sync_state)
			begin
				phase_cnt <= 8'h00;
				match_cnt <= 8'h00;
			end
			else if (dsp_in.symbol_valid)
			begin
				phase_cnt <= phase_cnt + 8'h01;
				if (sync_state == rtb_pkg::RTB_SYNC_ONES && match)
					match_cnt <= match_cnt + 8'h01;
			end
		end
	end

	// Alarm events
	always_comb
	begin
		irq_events = 4'h0;
		irq_events[`RTB_IRQ_FE_HIGH] = dsp_in.meter_valid &&
			dsp_in.far_end_meter > rtb_pkg::rtb_word_t'(remote_level_upper_limit);
		irq_events[`RTB_IRQ_FE_LOW] = dsp_in.meter_valid &&
			dsp_in.far_end_meter < rtb_pkg::rtb_word_t'(remote_level_lower_limit);
		irq_events[`RTB_IRQ_LOW_SNR] = dsp_in.meter_valid &&
			dsp_in.snr_meter > rtb_pkg::rtb_word_t'(quality_alarm_limit);
		irq_events[`RTB_IRQ_SYNC] = sync_event;
		clr_mask = (wr_en && idx == `RTB_IDX_IRQ_CLR) ? pwdata[3:0] : 4'h0;
		if (auto_sync)
			clr_mask[`RTB_IRQ_SYNC] = 1'b0;
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			irq_status <= (irq_status & ~clr_mask) | irq_events;
			irq <= |(((irq_status & ~clr_mask) | irq_events) & irq_enable);
		end
	end

	// Corrected datapath outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dsp_out <= '0;
		else
		begin
			dsp_out.phase_corr <= dsp_in.phase_det -
				rtb_pkg::rtb_word_t'(phase_error_offset);
			dsp_out.rx_corr <= dsp_in.rx_raw -
				rtb_pkg::rtb_word_t'(receive_dc_trim);
			// Correction zeroed only; adaptation sees the raw input
			dsp_out.ep_corr_out <= (hold_hit && dsp_in.symbol_valid) ||
				pause_left != 3'h0 ? 16'sh0000 : dsp_in.ep_correction;
			dsp_out.symbol <= sym_now;
			dsp_out.slicer_err <= err_now;
			dsp_out.dagc_err <= eq_select ? err_now :
				mag16(dsp_in.dagc_out) -
				rtb_pkg::rtb_word_t'(gain_loop_setpoint);
			dsp_out.tx_gain <=
				transmit_level_adjust[`RTB_GAIN_MSB:`RTB_GAIN_LSB];
			dsp_out.hist_hit <= hist_hit_now && dsp_in.symbol_valid;
			case (sync_state)
				rtb_pkg::RTB_SYNC_DESCR: dsp_out.scr_mode <= 2'h1;
				rtb_pkg::RTB_SYNC_ONES, rtb_pkg::RTB_SYNC_DONE:
					dsp_out.scr_mode <= 2'h2;
				default: dsp_out.scr_mode <= 2'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> tb/rtb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_monitor (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Write
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire rtb_pkg::rtb_dsp_in_s dsp_in, // Datapath in
	input wire rtb_pkg::rtb_dsp_out_s dsp_out, // Datapath out
	input wire logic irq // Interrupt
);
	logic [1:0] live;
	logic [3:0] gain_wd;
	logic gain_wr;
	assign gain_wd = pwdata[5:2];
	assign gain_wr = psel && penable && pready && pwrite &&
		paddr[9:2] == 8'h29;
	// Outputs settle a few edges after reset
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			live <= 2'h0;
		else if (live != 2'h3)
			live <= live + 2'h1;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_needs_setup: assert property (
		pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_upper_zero: assert property (
		pready |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_err_reads_zero: assert property (
		pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_phase_offset_held: assert property (
		live == 2'h3 && !psel && !$past(psel) |=>
		$past(dsp_in.phase_det) - dsp_out.phase_corr ==
		$past(dsp_in.phase_det, 2) - $past(dsp_out.phase_corr))
		else $error("phase offset not applied steadily");
	a_dc_trim_held: assert property (
		live == 2'h3 && !psel && !$past(psel) |=>
		$past(dsp_in.rx_raw) - dsp_out.rx_corr ==
		$past(dsp_in.rx_raw, 2) - $past(dsp_out.rx_corr))
		else $error("dc trim not applied steadily");
	a_symbol_legal: assert property (
		live == 2'h3 |->
		dsp_out.symbol inside {3'h5, 3'h7, 3'h1, 3'h3})
		else $error("illegal symbol");
	a_gain_follows: assert property (
		gain_wr |-> ##2 dsp_out.tx_gain == $past(gain_wd, 2))
		else $error("gain code not applied");
endmodule
bind rtb_core rtb_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .dsp_in(dsp_in),
	.dsp_out(dsp_out), .irq(irq));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	rtb_pkg::rtb_dsp_in_s din = '0;
	rtb_pkg::rtb_dsp_out_s dout;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] q;
	logic e;
	logic [15:0] v16;
	logic [7:0] lo_t [9] = '{8'h24, 8'h26, 8'h2a, 8'h2c, 8'h30,
		8'h32, 8'h34, 8'h36, 8'h38};
	logic signed [15:0] dfe_t [4] = '{16'sh00fa, 16'sh0096,
		-16'sh0096, -16'sh00fa};
	logic signed [2:0] sym_t [4] = '{3'sh3, 3'sh1, -3'sh1, -3'sh3};
	logic [15:0] fe_t [5] = '{16'h03e8, 16'h03e9, 16'h0064, 16'h0063, 16'h01f4};
	logic [15:0] sn_t [5] = '{16'h0032, 16'h0032, 16'h0032, 16'h0032, 16'h0033};
	logic [7:0] st_t [5] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h04};
	// Trim value is arbitrary
	rtb_core #(.FACTORY_TRIM(4'h9)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dsp_in(din), .dsp_out(dout), .irq(irq));
	always #25 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] ex,
		input logic [15:0] got);
		total_checks++;
		if (got !== ex)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, ex, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
		xfer(1'b1, lo, v[7:0]);
		xfer(1'b1, lo + 8'h01, v[15:8]);
	endtask
	task automatic rd16(input logic [7:0] lo);
		xfer(1'b0, lo, 8'h00);
		v16[7:0] = q[7:0];
		xfer(1'b0, lo + 8'h01, 8'h00);
		v16[15:8] = q[7:0];
	endtask
	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask
	// Counts zeroed corrections and histogram hits after one or two spikes
	task automatic pause_run(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] ez, input logic [15:0] eh);
		logic [15:0] z;
		logic [15:0] h;
		z = 16'h0000;
		h = 16'h0000;
		for (int t = 0; t < 16; t++)
		begin
			din.dfe_out <= (t == 0) ? a : (t == 2) ? b : 16'h0000;
			@(posedge pclk);
			if (dout.ep_corr_out === 16'h0000)
				z++;
			if (dout.hist_hit === 1'b1)
				h++;
		end
		chk("pause cycles", ez, z);
		chk("hist hits", eh, h);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (lo_t[i])
		begin
			rd16(lo_t[i]);
			chk("reset value", 16'h0000, v16);
		end
		xfer(1'b0, 8'h28, 8'h00);
		chk("trim", 16'h0024, q[15:0]);
		xfer(1'b1, 8'h28, 8'hff);
		xfer(1'b0, 8'h28, 8'h00);
		chk("trim ro", 16'h0024, q[15:0]);
		xfer(1'b1, 8'h29, q[7:0]);
		settle();
		chk("gain copy", 16'h0009, {12'h000, dout.tx_gain});
		for (int g = 0; g < 16; g++)
		begin
			xfer(1'b1, 8'h29, {2'h0, 4'(g), 2'h0});
			settle();
			chk("gain", 16'(g), {12'h000, dout.tx_gain});
		end
		foreach (lo_t[i])
		begin
			wr16(lo_t[i], {lo_t[i], ~lo_t[i]});
			rd16(lo_t[i]);
			chk("reg16", {lo_t[i], ~lo_t[i]}, v16);
		end
		xfer(1'b1, 8'h2e, 8'hff);
		xfer(1'b0, 8'h2e, 8'h00);
		chk("lock level", 16'h007f, q[15:0]);
		xfer(1'b1, 8'h2f, 8'h5a);
		chk("unmapped err", 16'h0001, {15'h0000, e});
		xfer(1'b0, 8'h2f, 8'h00);
		chk("unmapped read", 16'h0000, q[15:0]);
		$display("test registers done");
		wr16(8'h24, 16'hfff0);
		wr16(8'h26, 16'h0123);
		din.phase_det <= 16'h0064;
		din.rx_raw <= 16'hffce;
		settle();
		chk("phase", 16'h0074, dout.phase_corr);
		chk("dc", 16'hfeab, dout.rx_corr);
		$display("test offsets done");
		wr16(8'h36, 16'h0000);
		wr16(8'h2c, 16'h0064);
		wr16(8'h2a, 16'h0064);
		din.ep_correction <= 16'h0055;
		din.symbol_valid <= 1'b1;
		settle();
		pause_run(16'h0064, 16'h0000, 16'h0000, 16'h0000);
		pause_run(16'h0065, 16'h0000, 16'h0005, 16'h0001);
		pause_run(16'h0065, 16'hff9b, 16'h0007, 16'h0002);
		$display("test pause done");
		rd16(8'h44);
		chk("hist count", 16'h0003, v16);
		wr16(8'h36, 16'h0064);
		for (int k = 0; k < 4; k++)
		begin
			din.dfe_out <= dfe_t[k];
			settle();
			chk("symbol", 16'(sym_t[k]), 16'(dout.symbol));
			v16 = dfe_t[k] - sym_t[k] * 16'sh0064;
			chk("slicer err", v16, dout.slicer_err);
		end
		wr16(8'h38, 16'h0032);
		din.dagc_out <= 16'hffb0;
		settle();
		chk("dagc self", 16'h001e, dout.dagc_err);
		xfer(1'b1, 8'h40, 8'h02);
		settle();
		chk("dagc eq", 16'h0032, dout.dagc_err);
		xfer(1'b1, 8'h40, 8'h04);
		din.dfe_out <= dfe_t[1];
		settle();
		chk("two level pos", 16'h0003, 16'(dout.symbol));
		chk("two level err", 16'hff6a, dout.slicer_err);
		din.dfe_out <= dfe_t[2];
		settle();
		chk("two level neg", 16'hfffd, 16'(dout.symbol));
		chk("two level err", 16'h0096, dout.slicer_err);
		$display("test slicer done");
		wr16(8'h30, 16'h03e8);
		wr16(8'h32, 16'h0064);
		wr16(8'h34, 16'h0032);
		xfer(1'b1, 8'h43, 8'h07);
		for (int k = 0; k < 5; k++)
		begin
			xfer(1'b1, 8'h42, 8'h0f);
			din.far_end_meter <= fe_t[k];
			din.snr_meter <= sn_t[k];
			din.meter_valid <= 1'b1;
			@(posedge pclk);
			din.meter_valid <= 1'b0;
			settle();
			xfer(1'b0, 8'h41, 8'h00);
			chk("status", 16'(st_t[k]), q[15:0]);
			chk("irq", {15'h0000, |st_t[k]}, {15'h0000, irq});
		end
		xfer(1'b1, 8'h43, 8'h00);
		settle();
		chk("irq masked", 16'h0000, {15'h0000, irq});
		xfer(1'b1, 8'h43, 8'h04);
		settle();
		chk("irq unmasked", 16'h0001, {15'h0000, irq});
		xfer(1'b1, 8'h42, 8'h04);
		settle();
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		$display("test alarms done");
		// Sync: idle, a window one match short, then lock on the last match
		xfer(1'b1, 8'h2e, 8'h00);
		settle();
		xfer(1'b0, 8'h46, 8'h00);
		chk("sync off", 16'h0001, q[15:0]);
		xfer(1'b0, 8'h41, 8'h00);
		chk("no sync flag", 16'h0000, q[15:0]);
		xfer(1'b1, 8'h2e, 8'h7f);
		xfer(1'b1, 8'h40, 8'h01);
		xfer(1'b0, 8'h46, 8'h00);
		chk("descramble", 16'h0002, q[15:0]);
		repeat (200) @(posedge pclk);
		xfer(1'b0, 8'h41, 8'h00);
		chk("no lock at level", 16'h0000, q[15:0]);
		xfer(1'b1, 8'h40, 8'h00);
		xfer(1'b1, 8'h2e, 8'h7e);
		xfer(1'b1, 8'h40, 8'h01);
		repeat (200) @(posedge pclk);
		xfer(1'b0, 8'h46, 8'h00);
		chk("locked", 16'h0008, q[15:0]);
		chk("ones mode", 16'h0002, {14'h0000, dout.scr_mode});
		xfer(1'b1, 8'h42, 8'h08);
		xfer(1'b0, 8'h41, 8'h00);
		chk("sync flag held", 16'h0008, q[15:0]);
		xfer(1'b1, 8'h40, 8'h00);
		xfer(1'b1, 8'h42, 8'h08);
		xfer(1'b0, 8'h41, 8'h00);
		chk("sync flag cleared", 16'h0000, q[15:0]);
		xfer(1'b0, 8'h46, 8'h00);
		chk("sync idle", 16'h0001, q[15:0]);
		$display("test sync done");
		summarize();
	end
endmodule
`default_nettype wire
